// *** src/self_program_flash_pkg.sv ***
// constants shared by the self-programming flash controller
package self_program_flash_pkg;
    // apb register map (byte addresses)
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    // control register bit positions
    localparam int IRQ_EN_BIT   = 7;
    localparam int BUSY_BIT     = 6;
    localparam int REEN_BIT     = 4;
    localparam int LOCKSEL_BIT  = 3;
    localparam int PGWRITE_BIT  = 2;
    localparam int PGERASE_BIT  = 1;
    localparam int STORE_PROGRAM_ENABLE_BIT    = 0;
    // accepted lower five control patterns
    localparam logic [4:0] CMD_REENABLE = 5'b1_0001;
    localparam logic [4:0] CMD_LOCKSET  = 5'b0_1001;
    localparam logic [4:0] CMD_PGWRITE  = 5'b0_0101;
    localparam logic [4:0] CMD_PGERASE  = 5'b0_0011;
    localparam logic [4:0] CMD_PGLOAD   = 5'b0_0001;
    // arming windows in clock cycles
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [1:0] LPM_WINDOW = 2'h3;
    // flash geometry: 128-word pages, concurrent region is pages 0..223
    localparam int          WORDS_PER_PAGE = 128;
    localparam logic [7:0]  NO_CONCURRENT_READ_REGION_FIRST_PAGE = 8'hE0;
    localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
    // load-program z values selecting fuse and lock bytes
    localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
    localparam logic [1:0] SEL_LOCK      = 2'h1;
    localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
    localparam logic [1:0] UNUSED_ONES   = 2'h3;
    localparam logic [5:0] EXT_UNUSED    = 6'h3F;
    // operation codes towards the flash array
    localparam logic [1:0] OP_ERASE = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_LOCK  = 2'h2;
    typedef enum logic [1:0] {
        OP_IDLE   = 2'b00,
        OP_LAUNCH = 2'b01,
        OP_RUN    = 2'b11
    } op_state_e;
endpackage

// *** src/self_program_flash_control.sv ***
// self-programming controller: control register, page buffer, flash sequencing
`timescale 1ns/10ps
`default_nettype none
module self_program_flash_control
    import self_program_flash_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // core store-program and load-program path
    input  wire logic        spm_strobe,
    input  wire logic        lpm_strobe,
    input  wire logic [15:0] z_pointer,
    input  wire logic [15:0] spm_word,
    output logic             lpm_valid,
    output logic [7:0]       lpm_rdata,
    output logic             cpu_halt,
    output logic             program_ready_irq,
    output logic             concurrent_read_block,
    // eeprom and nonvolatile bytes (raw cell levels, 1 = unprogrammed)
    input  wire logic        eeprom_write_busy,
    input  wire logic [7:0]  fuse_low_byte,
    input  wire logic [7:0]  fuse_high_byte,
    input  wire logic [1:0]  extended_fuse_byte,
    input  wire logic [5:0]  lock_byte,
    // flash array
    input  wire logic        flash_busy,
    input  wire logic [6:0]  flash_buf_index,
    output logic             flash_start,
    output logic [1:0]       flash_cmd,
    output logic [7:0]       flash_page,
    output logic [3:0]       flash_lock_mask,
    output logic [15:0]      flash_buf_word
);

    typedef struct packed {
        logic                      irq_en;
        logic                      busy;
        logic                      reen;
        logic                      locksel;
        logic                      pgwrite;
        logic                      pgerase;
        logic                      store_program_enable;
        logic [2:0]                spm_win;
        logic [1:0]                lpm_win;
        op_state_e                 state;
        logic                      halt;
        logic                      start;
        logic [1:0]                cmd;
        logic [7:0]                page;
        logic [3:0]                mask;
        logic [7:0]                lpm_data;
        logic                      lpm_hit;
        logic [WORDS_PER_PAGE-1:0] valid;
        logic [31:0]               rdata;
        logic                      sync1;
        logic                      sync2;
    } ctrl_s;

    ctrl_s       r_reg;
    ctrl_s       r_next;
    logic [15:0] page_buf [WORDS_PER_PAGE];
    logic [15:0] buf_word_reg;
    logic [4:0]  low5;
    logic        ctrl_wr;
    logic        spm_take;
    logic        lpm_take;
    logic        load_take;
    logic [7:0]  ctrl_view;
    logic [7:0]  nv_byte;

    ////////////////////////////////////////////////////////////////////////////
    // decode of bus and core requests
    // store_program_enable reads set while an operation runs, even across a reset
    assign ctrl_view = {r_reg.irq_en, r_reg.busy, 1'b0, r_reg.reen, r_reg.locksel,
                        r_reg.pgwrite, r_reg.pgerase, r_reg.store_program_enable | r_reg.sync2};
    assign low5      = pwdata[4:0];
    assign ctrl_wr   = psel && penable && pwrite && (paddr == CTRL_OFFSET);
    // store-program only counts while armed and no eeprom write runs
    assign spm_take  = spm_strobe && r_reg.store_program_enable && (r_reg.spm_win != 3'h0)
                       && (r_reg.state == OP_IDLE) && !eeprom_write_busy;
    assign lpm_take  = lpm_strobe && r_reg.store_program_enable && r_reg.locksel
                       && (r_reg.lpm_win != 2'h0) && !eeprom_write_busy;
    assign load_take = spm_take && !r_reg.reen && !r_reg.locksel
                       && !r_reg.pgwrite && !r_reg.pgerase;

    // raw cells pass straight: programmed reads 0, unprogrammed reads 1
    always_comb begin
        unique case (z_pointer[1:0])
            SEL_FUSE_LOW:  nv_byte = fuse_low_byte;
            SEL_LOCK:      nv_byte = {UNUSED_ONES, lock_byte};
            SEL_FUSE_EXT:  nv_byte = {EXT_UNUSED, extended_fuse_byte};
            SEL_FUSE_HIGH: nv_byte = fuse_high_byte;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next       = r_reg;
        r_next.start = 1'b0;
        r_next.lpm_hit = 1'b0;
        // flash busy is asynchronous to pclk
        r_next.sync1 = flash_busy;
        r_next.sync2 = r_reg.sync1;
        if (r_reg.spm_win != 3'h0) begin
            r_next.spm_win = r_reg.spm_win - 3'h1;
        end
        if (r_reg.lpm_win != 2'h0) begin
            r_next.lpm_win = r_reg.lpm_win - 2'h1;
        end
        // expiry of an unused window drops the command bits
        if (r_reg.spm_win == 3'h1 && r_reg.state == OP_IDLE && !spm_take && !lpm_take) begin
            r_next.store_program_enable   = 1'b0;
            r_next.reen    = 1'b0;
            r_next.locksel = 1'b0;
            r_next.pgwrite = 1'b0;
            r_next.pgerase = 1'b0;
        end
        // apb setup phase captures read data
        if (psel && !penable) begin
            unique case (paddr)
                CTRL_OFFSET:   r_next.rdata = {24'h00_0000, ctrl_view};
                STATUS_OFFSET: r_next.rdata = {28'h000_0000, r_reg.halt, r_reg.sync2,
                                               r_reg.state};
                default:       r_next.rdata = 32'h0000_0000;
            endcase
        end
        // control write: interrupt enable always, command bits only when accepted
        if (ctrl_wr) begin
            r_next.irq_en = pwdata[IRQ_EN_BIT];
            if (!r_reg.store_program_enable && !r_reg.sync2 && !eeprom_write_busy
                && (low5 == CMD_REENABLE || low5 == CMD_LOCKSET || low5 == CMD_PGWRITE
                    || low5 == CMD_PGERASE || low5 == CMD_PGLOAD)) begin
                r_next.reen    = pwdata[REEN_BIT];
                r_next.locksel = pwdata[LOCKSEL_BIT];
                r_next.pgwrite = pwdata[PGWRITE_BIT];
                r_next.pgerase = pwdata[PGERASE_BIT];
                r_next.store_program_enable   = pwdata[STORE_PROGRAM_ENABLE_BIT];
                r_next.spm_win = SPM_WINDOW;
                r_next.lpm_win = LPM_WINDOW;
            end
        end
        // load-program of fuse or lock byte
        if (lpm_take) begin
            r_next.lpm_data = nv_byte;
            r_next.lpm_hit  = 1'b1;
            r_next.store_program_enable    = 1'b0;
            r_next.locksel  = 1'b0;
            r_next.spm_win  = 3'h0;
            r_next.lpm_win  = 2'h0;
        end else if (spm_take) begin
            r_next.spm_win = 3'h0;
            if (r_reg.pgwrite || r_reg.pgerase || r_reg.locksel) begin
                // page address latched; r0 ignored for erase and write
                r_next.start = 1'b1;
                r_next.state = OP_LAUNCH;
                r_next.page  = z_pointer[15:8];
                r_next.mask  = ~spm_word[5:2];
                r_next.cmd   = r_reg.locksel ? OP_LOCK :
                               (r_reg.pgwrite ? OP_WRITE : OP_ERASE);
                if (!r_reg.locksel) begin
                    if (z_pointer[15:8] < NO_CONCURRENT_READ_REGION_FIRST_PAGE) begin
                        r_next.busy = 1'b1;
                    end else begin
                        r_next.halt = 1'b1;
                    end
                end
            end else begin
                r_next.store_program_enable = 1'b0;
                r_next.reen  = 1'b0;
                if (r_reg.reen) begin
                    r_next.busy  = 1'b0;
                    r_next.valid = '0;
                end else begin
                    r_next.busy = 1'b0;
                    r_next.valid[z_pointer[7:1]] = 1'b1;
                end
            end
        end
        // operation sequencing: wait for busy to rise, then to fall
        unique case (r_reg.state)
            OP_IDLE: begin
            end
            OP_LAUNCH: begin
                if (r_reg.sync2) begin
                    r_next.state = OP_RUN;
                end
            end
            OP_RUN: begin
                if (!r_reg.sync2) begin
                    r_next.state   = OP_IDLE;
                    r_next.store_program_enable   = 1'b0;
                    r_next.halt    = 1'b0;
                    r_next.locksel = 1'b0;
                    r_next.pgerase = 1'b0;
                    r_next.pgwrite = 1'b0;
                    if (r_reg.cmd == OP_WRITE) begin
                        r_next.valid = '0;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; a running flash write is never aborted by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // page buffer storage; erased state comes from the valid bits, no reset needed
    always_ff @(posedge pclk) begin
        if (load_take) begin
            page_buf[z_pointer[7:1]] <= spm_word;
        end
        buf_word_reg <= r_reg.valid[flash_buf_index] ? page_buf[flash_buf_index]
                                                     : ERASED_WORD;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign pready                = 1'b1;
    assign pslverr               = psel && penable && (paddr != CTRL_OFFSET)
                                   && (paddr != STATUS_OFFSET);
    assign prdata                = r_reg.rdata;
    assign lpm_valid             = r_reg.lpm_hit;
    assign lpm_rdata             = r_reg.lpm_data;
    assign cpu_halt              = r_reg.halt;
    assign program_ready_irq     = r_reg.irq_en && !ctrl_view[STORE_PROGRAM_ENABLE_BIT];
    assign concurrent_read_block = r_reg.busy;
    assign flash_start           = r_reg.start;
    assign flash_cmd             = r_reg.cmd;
    assign flash_page            = r_reg.page;
    assign flash_lock_mask       = r_reg.mask;
    assign flash_buf_word        = buf_word_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence load_armed_s;
        ctrl_wr && (low5 == CMD_PGLOAD) && !r_reg.store_program_enable && !r_reg.sync2 && !eeprom_write_busy;
    endsequence
    sequence no_spm4_s;
        (!spm_strobe && !lpm_strobe) [*4];
    endsequence
    // completion edge of a running erase, write or lock set
    sequence op_done_s;
        r_reg.state == OP_RUN && !r_reg.sync2;
    endsequence

    irq_level_a: assert property (
        program_ready_irq == (r_reg.irq_en && !r_reg.store_program_enable && !r_reg.sync2))
        else $error("ready irq level wrong");
    window_expiry_a: assert property (load_armed_s ##1 no_spm4_s |=> !r_reg.store_program_enable)
        else $error("enable outlived its window");
    load_clears_a: assert property (load_take
        |=> !r_reg.busy && !r_reg.store_program_enable && r_reg.valid[$past(z_pointer[7:1])])
        else $error("page load effect wrong");
    reenable_erase_a: assert property (spm_take && r_reg.reen
        |=> r_reg.valid == '0 && !concurrent_read_block)
        else $error("re-enable did not erase");
    no_concurrent_read_region_halt_a: assert property (spm_take && r_reg.pgwrite
        && z_pointer[15:8] >= NO_CONCURRENT_READ_REGION_FIRST_PAGE |=> cpu_halt && flash_start)
        else $error("no halt for write");
    rww_busy_a: assert property (spm_take && r_reg.pgerase
        && z_pointer[15:8] < NO_CONCURRENT_READ_REGION_FIRST_PAGE |=> concurrent_read_block && !cpu_halt)
        else $error("busy flag not set");
    eeprom_block_a: assert property (eeprom_write_busy && (spm_strobe || lpm_strobe)
        |=> !lpm_valid && !flash_start) else $error("eeprom did not block");
    lock_read_a: assert property (lpm_take && z_pointer[1:0] == SEL_LOCK
        |=> lpm_valid && lpm_rdata == {UNUSED_ONES, $past(lock_byte)} && !r_reg.store_program_enable)
        else $error("lock byte read wrong");
    lock_nohalt_a: assert property (r_reg.cmd == OP_LOCK && r_reg.state != OP_IDLE
        |-> !cpu_halt && !concurrent_read_block) else $error("lock set blocked flash");
    enable_held_a: assert property (r_reg.state != OP_IDLE |-> r_reg.store_program_enable)
        else $error("enable dropped early");
    bad_pattern_a: assert property (ctrl_wr && !r_reg.store_program_enable && low5 == 5'b0_0111
        |=> !r_reg.store_program_enable) else $error("illegal pattern accepted");

    // fuse bytes pass straight through, one result per arming
    fuse_low_a: assert property (lpm_take && z_pointer[1:0] == SEL_FUSE_LOW
        |=> lpm_valid && lpm_rdata == $past(fuse_low_byte))
        else $error("fuse low byte read wrong");
    fuse_high_a: assert property (lpm_take && z_pointer[1:0] == SEL_FUSE_HIGH
        |=> lpm_valid && lpm_rdata == $past(fuse_high_byte))
        else $error("fuse high byte read wrong");
    fuse_ext_a: assert property (lpm_take && z_pointer[1:0] == SEL_FUSE_EXT
        |=> lpm_valid && lpm_rdata == {EXT_UNUSED, $past(extended_fuse_byte)})
        else $error("extended fuse byte read wrong");
    lpm_once_a: assert property (lpm_valid |=> !lpm_valid)
        else $error("second byte read without arming");
    busy_hold_a: assert property (concurrent_read_block && !spm_take
        |=> concurrent_read_block) else $error("busy flag dropped early");
    start_pulse_a: assert property (flash_start |=> !flash_start)
        else $error("start pulse too long");
    done_release_a: assert property (op_done_s |=> !cpu_halt && !r_reg.store_program_enable)
        else $error("halt or enable kept after completion");
    write_erase_a: assert property (r_reg.state == OP_RUN && !r_reg.sync2
        && r_reg.cmd == OP_WRITE |=> r_reg.valid == '0)
        else $error("buffer kept after page write");

endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking testbench for the self-programming flash controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    import self_program_flash_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, lpm_rdata, flash_page;
    logic [31:0] pwdata, prdata, rd;
    logic        spm_strobe, lpm_strobe, lpm_valid, cpu_halt, program_ready_irq;
    logic        concurrent_read_block, eeprom_write_busy, flash_busy, flash_start;
    logic [15:0] z_pointer, spm_word, flash_buf_word;
    logic [6:0]  flash_buf_index;
    logic [1:0]  flash_cmd;
    logic [3:0]  flash_lock_mask;
    logic [7:0]  fuse_tbl [4];
    int          fail_count, cmp_count;
    self_program_flash_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .spm_strobe(spm_strobe),
        .lpm_strobe(lpm_strobe), .z_pointer(z_pointer), .spm_word(spm_word),
        .lpm_valid(lpm_valid), .lpm_rdata(lpm_rdata), .cpu_halt(cpu_halt),
        .program_ready_irq(program_ready_irq),
        .concurrent_read_block(concurrent_read_block),
        .eeprom_write_busy(eeprom_write_busy), .fuse_low_byte(8'h5A),
        .fuse_high_byte(8'hC3), .extended_fuse_byte(2'b10), .lock_byte(6'b10_1101),
        .flash_busy(flash_busy), .flash_buf_index(flash_buf_index),
        .flash_start(flash_start), .flash_cmd(flash_cmd), .flash_page(flash_page),
        .flash_lock_mask(flash_lock_mask), .flash_buf_word(flash_buf_word));
    ////////////////////////////////////////////////////////////////////////////
    // clock, 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a used-up wait counts as a mismatch and closes the run
    task automatic timed_out();
        fail_count++;
        print_verdict();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // apb master: setup cycle, then access held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) timed_out();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_ctrl(input logic [7:0] v);
        logic [31:0] q;
        logic        e;
        apb(1'b1, CTRL_OFFSET, {24'h0, v}, q, e);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    // one-cycle core strobes, settled output looked at after the answer edge
    task automatic strobe(input logic lpm, input logic [15:0] z, input logic [15:0] w);
        @(posedge pclk);
        spm_strobe <= !lpm;
        lpm_strobe <= lpm;
        z_pointer <= z;
        spm_word <= w;
        @(posedge pclk);
        spm_strobe <= 1'b0;
        lpm_strobe <= 1'b0;
        #1;
    endtask
    task automatic buf_word(input logic [6:0] idx, input logic [15:0] exp);
        @(posedge pclk);
        flash_buf_index <= idx;
        repeat (2) @(posedge pclk);
        #1 check(flash_buf_word, exp);
    endtask
    // launch an array operation, play the array's busy level, wait for the end
    task automatic flash_op(input logic [7:0] c, input logic [15:0] z, input logic [15:0] w,
                            input logic [1:0] cmd, input logic halt, input logic blk);
        int k;
        wr_ctrl(c);
        strobe(1'b0, z, w);
        check(flash_start, 1'b1);
        check(flash_cmd, cmd);
        if (cmd != OP_LOCK) check(flash_page, z[15:8]);
        @(posedge pclk);
        flash_busy <= 1'b1;
        repeat (5) @(posedge pclk);
        #1 check(cpu_halt, halt);
        check(concurrent_read_block, blk);
        check(program_ready_irq, 1'b0);
        rd_reg(CTRL_OFFSET, rd);
        check(rd[0], 1'b1);
        flash_busy <= 1'b0;
        for (k = 0; k < 50; k++) begin
            rd_reg(CTRL_OFFSET, rd);
            if (rd[0] === 1'b0) break;
        end
        if (k == 50) timed_out();
        check(rd, {24'h0, c[7], blk, 6'h0});
        check(cpu_halt, 1'b0);
        check(program_ready_irq, c[7]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic e;
        {psel, penable, pwrite, spm_strobe, lpm_strobe, eeprom_write_busy} = '0;
        {paddr, pwdata, z_pointer, spm_word, flash_buf_index, flash_busy} = '0;
        fuse_tbl = '{8'h5A, 8'hED, 8'hFE, 8'hC3};
        fail_count = 0;
        cmp_count = 0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_reg(CTRL_OFFSET, rd);
        check(rd, {24'h0, CTRL_RESET});
        rd_reg(STATUS_OFFSET, rd);
        check(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rd, e);
        check(rd, 32'h0);
        check(e, 1'b1);
        $display("test reset done");
        // load word 0x1234 at index 5, then a strobe after the window closes
        wr_ctrl(8'h01);
        strobe(1'b0, 16'h000A, 16'h1234);
        rd_reg(CTRL_OFFSET, rd);
        check(rd, 32'h0);
        buf_word(7'd5, 16'h1234);
        wr_ctrl(8'h01);
        repeat (6) @(posedge pclk);
        strobe(1'b0, 16'h000C, 16'hBEEF);
        rd_reg(CTRL_OFFSET, rd);
        check(rd, 32'h0);
        buf_word(7'd6, ERASED_WORD);
        foreach (fuse_tbl[i]) begin
            wr_ctrl(8'h07 + 8'(i * 8));
            rd_reg(CTRL_OFFSET, rd);
            check(rd, 32'h0);
        end
        $display("test page load done");
        // region write with irq enabled, then a page load clears the busy flag
        flash_op(8'h85, 16'h1000, 16'h0, OP_WRITE, 1'b0, 1'b1);
        buf_word(7'd5, ERASED_WORD);
        wr_ctrl(8'h01);
        strobe(1'b0, 16'h0002, 16'h0042);
        check(concurrent_read_block, 1'b0);
        flash_op(8'h03, 16'h2000, 16'h0, OP_ERASE, 1'b0, 1'b1);
        wr_ctrl(8'h11);
        strobe(1'b0, 16'h0000, 16'h0);
        repeat (2) @(posedge pclk);
        #1 check(concurrent_read_block, 1'b0);
        buf_word(7'd1, ERASED_WORD);
        flash_op(8'h05, 16'hF000, 16'h0, OP_WRITE, 1'b1, 1'b0);
        $display("test page write done");
        // lock data bits 5 and 3 zero: upper bit2 and app bit2 programmed
        flash_op(8'h09, 16'h0001, 16'h00D7, OP_LOCK, 1'b0, 1'b0);
        check(flash_lock_mask, 4'b1010);
        foreach (fuse_tbl[i]) begin
            wr_ctrl(8'h09);
            strobe(1'b1, 16'(i), 16'h0);
            check({lpm_valid, lpm_rdata}, {1'b1, fuse_tbl[i]});
            rd_reg(CTRL_OFFSET, rd);
            check(rd, 32'h0);
        end
        $display("test lock and fuse done");
        // reset in mid-write: the array keeps running, the buffer is erased
        wr_ctrl(8'h01);
        strobe(1'b0, 16'h0006, 16'hA55A);
        wr_ctrl(8'h05);
        strobe(1'b0, 16'h1100, 16'h0);
        @(posedge pclk);
        flash_busy <= 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // busy level needs two edges through the synchroniser
        repeat (2) @(posedge pclk);
        rd_reg(CTRL_OFFSET, rd);
        check(rd, 32'h1);
        buf_word(7'd3, ERASED_WORD);
        @(posedge pclk);
        flash_busy <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_reg(CTRL_OFFSET, rd);
        check(rd, 32'h0);
        $display("test reset in write done");
        // eeprom write in progress refuses the arming write and an armed read
        @(posedge pclk);
        eeprom_write_busy <= 1'b1;
        wr_ctrl(8'h09);
        strobe(1'b1, 16'h0001, 16'h0);
        check(lpm_valid, 1'b0);
        rd_reg(CTRL_OFFSET, rd);
        check(rd, 32'h0);
        eeprom_write_busy <= 1'b0;
        wr_ctrl(8'h09);
        eeprom_write_busy <= 1'b1;
        strobe(1'b1, 16'h0001, 16'h0);
        check(lpm_valid, 1'b0);
        eeprom_write_busy <= 1'b0;
        $display("test eeprom block done");
        print_verdict();
    end
endmodule
`default_nettype wire
